/* rtl/pdi_params.svh */
// Constants of the process and diagnostic interrupt unit.
// Assumes inclusion by bare name from rtl files only.
// Summary of operation
// - Bytes 8 and 9 flag input edges
// - Byte 10 holds counter 0 and 1 events
// - Byte 11 holds counter 2 events, rest reserved
// - Frequency mode flags integration end per channel
// - Report carries module base address and event word
// - Diagnostics need technology function and combined setting
// - Parameter record 7Fh sets global diagnostic enable
// - Repeat event during service raises incoming diagnostic
// - Incoming diagnostic preempts running process service
// - Queued diagnostics first in order, then process
// - Held channel discards further process requests
// - Finished triggering process raises outgoing diagnostic
// - Events between incoming and outgoing are dropped
// - Fault indicator lit from first incoming to last outgoing
// - Each diagnostic dispatch writes one buffer entry
// - Record 0 ready before diagnostic handler starts
// - Last diagnostic event and record 1 stay readable
// - Byte 0 flags channel error only, failure and external bits stay 0
// - Byte 1 gives class and channel info flag
// - Byte 2 zero, byte 3 bit 6 lost
// - Process report needs output enable and combined setting
// - Pulse width modulation gives no process reports
`ifndef PDI_PARAMS_SVH
`define PDI_PARAMS_SVH
`define PDI_REC_ERR 3'h0
`define PDI_REC_CLASS 3'h1
`define PDI_REC_ZERO 3'h2
`define PDI_REC_LOST 3'h3
`define PDI_REC1_TYPE 3'h4
`define PDI_REC1_BITS 3'h5
`define PDI_REC1_CHANS 3'h6
`define PDI_REC1_GROUP 3'h7
`define PDI_B0_FAIL 0
`define PDI_B0_EXT 2
`define PDI_B0_CHERR 3
`define PDI_B1_CHINFO 4
`define PDI_B3_LOST 6
`define PDI_CLASS_DIGITAL 4'hf
`define PDI_CH_TYPE 8'h70
`define PDI_DIAG_BITS 8'h08
`define PDI_CH_COUNT 8'h08
`define PDI_PARAM_GLOBAL_DIAG 8'h7f
`define PDI_RSV_COUNT 32'hf000_0000
`define PDI_RSV_FREQ 32'hfeee_0000
`define PDI_QDEPTH 16
`endif

/* rtl/pdi_pkg.sv */
// Types and shared decoding of the interrupt unit.
// Assumes nothing of its surroundings.
package pdi_pkg;
    typedef enum logic [1:0] {
        MODE_NONE = 2'h0,
        MODE_COUNT = 2'h1,
        MODE_FREQ = 2'h2,
        MODE_PWM = 2'h3
    } mode_e;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_PROC = 3'h2,
        ST_DIAG = 3'h4
    } state_e;
    typedef struct packed {
        logic outg;
        logic [2:0] chan;
    } qent_s;
    // Channel k owns event word bits 4k..4k+3
    function automatic logic [6:0] chanOf(input logic [31:0] w);
        logic [6:0] c;
        c = '0;
        for (int k = 0; k < 7; k++) begin
            c[k] = |w[4*k +: 4];
        end
        return c;
    endfunction
    function automatic logic [31:0] bitsOf(input logic [6:0] c);
        logic [31:0] w;
        w = '0;
        for (int k = 0; k < 7; k++) begin
            w[4*k +: 4] = {4{c[k]}};
        end
        return w;
    endfunction
endpackage

/* rtl/evt_if.sv */
// Event word path from the mapper to the interrupt core.
// Assumes one clock for both ends.
interface evt_if;
    logic [31:0] word;
    logic [6:0] hit;
    modport src (output word, output hit);
    modport snk (input word, input hit);
endinterface

/* rtl/process_event_mapper.sv */
// Builds the event word from pins and technology events.
// Assumes inPins asynchronous, other events on clk.
`include "pdi_params.svh"
module process_event_mapper (
    input wire logic clk, // System clock
    input wire logic arst_n, // Async reset
    input wire logic [15:0] inPins, // Digital inputs 0.0..1.7
    input wire logic [11:0] ctrEvt, // Counter event pulses
    input wire logic [2:0] freqEnd, // Integration end pulses
    input wire pdi_pkg::mode_e techMode, // Technology function
    evt_if.src ev // Event word out
);
    import pdi_pkg::*;
    logic [15:0] sync1Q, sync2Q, prevQ;
    logic [31:0] wordQ, word_d;

    always_comb begin
        logic [15:0] edges;
        edges = sync2Q ^ prevQ;
        case (techMode)
            MODE_COUNT: word_d = {4'h0, ctrEvt, edges};
            MODE_FREQ: word_d = {7'h0, freqEnd[2], 3'h0, freqEnd[1],
                3'h0, freqEnd[0], edges};
            default: word_d = '0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1Q <= '0;
            sync2Q <= '0;
            prevQ <= '0;
            wordQ <= '0;
        end else begin
            sync1Q <= inPins;
            sync2Q <= sync1Q;
            prevQ <= sync2Q;
            wordQ <= word_d;
        end
    end

    assign ev.word = wordQ;
    assign ev.hit = chanOf(wordQ);
endmodule // process_event_mapper

/* rtl/process_diag_interrupt_unit.sv */
// Process and diagnostic interrupt unit: escalation, queue, record.
// Assumes CPU handlers acknowledge by procDone and diagDone pulses.
`include "pdi_params.svh"
module process_diag_interrupt_unit (
    input wire logic clk, // System clock
    input wire logic arst_n, // Async reset
    input wire logic [15:0] inPins, // Digital inputs 0.0..1.7
    input wire logic [11:0] ctrEvt, // Counter events, 4 per counter
    input wire logic [2:0] freqEnd, // Integration end per channel
    input wire pdi_pkg::mode_e techMode, // Technology function
    input wire logic diagProcCfg, // Diagnostics+process setting
    input wire logic counterOutEn, // Counter output enabled
    input wire logic paramWr, // Parameter record write
    input wire logic [7:0] paramIdx, // Parameter record number
    input wire logic [7:0] paramData, // Parameter record data
    input wire logic [15:0] baseAddr, // Module base address
    input wire logic procDone, // Process handler finished
    input wire logic diagDone, // Diagnostic handler finished
    input wire logic [2:0] rdIdx, // Record byte select
    output logic procIrq, // Process handler request
    output logic [31:0] eventWord, // Event double word
    output logic [15:0] eventBase, // Base address word
    output logic diagIrq, // Diagnostic handler request
    output logic [31:0] diagRecord, // Record 0, byte 0 low
    output logic faultLed, // System fault indicator
    output logic bufWr, // Diagnostic buffer write
    output logic [31:0] bufEntry, // Buffer entry
    output logic [7:0] rdData // Record read data
);
    import pdi_pkg::*;

    ////////////////////////////////////////////////////////////////////
    evt_if ev();
    process_event_mapper u_map (
        .clk(clk),
        .arst_n(arst_n),
        .inPins(inPins),
        .ctrEvt(ctrEvt),
        .freqEnd(freqEnd),
        .techMode(techMode),
        .ev(ev)
    );

    function automatic logic [2:0] lowIdx(input logic [6:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int k = 6; k >= 0; k--) begin
            if (m[k]) begin
                r = 3'(k);
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] mkRec(input logic chErr,
                                          input logic lost);
        logic [31:0] r;
        r = '0;
        r[`PDI_B0_CHERR] = chErr;
        r[11:8] = `PDI_CLASS_DIGITAL;
        r[8 + `PDI_B1_CHINFO] = 1'b1;
        r[24 + `PDI_B3_LOST] = lost;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    state_e state_q, state_d;
    logic procIrqQ, procIrq_d, diagIrqQ, diagIrq_d;
    logic globQ, glob_d, faultQ, fault_d, bufWrQ, bufWr_d;
    logic [31:0] wordQ, word_d, pendQ, pend_d, recQ, rec_d;
    logic [31:0] bufEntQ, bufEnt_d;
    logic [15:0] baseQ, base_d;
    logic [6:0] procChQ, procCh_d, holdQ, hold_d, incQ, inc_d;
    logic [6:0] outQ, out_d, trigQ, trig_d, grpQ, grp_d;
    logic [7:0] rdQ_data, rdData_d;
    qent_s qMem [`PDI_QDEPTH];
    logic [3:0] wrQ, wr_d, rdQ, rd_d;
    logic [4:0] cntQ, cnt_d;
    logic push;
    qent_s pushEnt, cur;
    logic procEn, diagEn;
    logic [6:0] hitG, dropCh, repCh, keepCh;
    logic [31:0] keepBits;

    assign procEn = counterOutEn && diagProcCfg
        && (techMode == MODE_COUNT || techMode == MODE_FREQ);
    assign diagEn = techMode != MODE_NONE && diagProcCfg && globQ;
    assign hitG = procEn ? ev.hit : 7'h0;
    assign dropCh = hitG & holdQ;
    assign repCh = hitG & ~holdQ & procChQ & {7{procIrqQ}};
    // A repeat is never kept: escalated or, with diagnostics off, lost
    assign keepCh = hitG & ~dropCh & ~repCh;
    assign keepBits = ev.word & bitsOf(keepCh);
    assign cur = qMem[rdQ];

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        procIrq_d = procIrqQ;
        diagIrq_d = diagIrqQ;
        word_d = wordQ;
        base_d = baseQ;
        procCh_d = procChQ;
        pend_d = pendQ | keepBits;
        hold_d = holdQ;
        inc_d = incQ;
        out_d = outQ;
        trig_d = trigQ;
        rec_d = recQ;
        grp_d = grpQ;
        bufWr_d = 1'b0;
        bufEnt_d = bufEntQ;
        glob_d = globQ;
        wr_d = wrQ;
        rd_d = rdQ;
        cnt_d = cntQ;
        push = 1'b0;
        pushEnt = '0;
        if (paramWr && paramIdx == `PDI_PARAM_GLOBAL_DIAG) begin
            glob_d = paramData[0];
        end
        if (diagEn) begin
            hold_d = hold_d | repCh;
            inc_d = inc_d | repCh;
            trig_d = trig_d | repCh;
        end else if (|repCh) begin
            rec_d = mkRec(1'b1, 1'b1);
            grp_d = grp_d | repCh;
        end
        if (procDone && procIrqQ) begin
            procIrq_d = 1'b0;
            procCh_d = '0;
            out_d = out_d | trig_d;
            trig_d = '0;
        end
        if (cntQ < 5'(`PDI_QDEPTH) && |inc_d) begin
            push = 1'b1;
            pushEnt = '{outg: 1'b0, chan: lowIdx(inc_d)};
            inc_d = inc_d & ~(7'h1 << lowIdx(inc_d));
        end else if (cntQ < 5'(`PDI_QDEPTH) && |out_d) begin
            push = 1'b1;
            pushEnt = '{outg: 1'b1, chan: lowIdx(out_d)};
            out_d = out_d & ~(7'h1 << lowIdx(out_d));
        end
        case (state_q)
            ST_IDLE, ST_PROC: begin
                if (cntQ != 5'h0) begin
                    state_d = ST_DIAG;
                    diagIrq_d = 1'b1;
                    rd_d = rdQ + 4'h1;
                    cnt_d = cnt_d - 5'h1;
                    rec_d = mkRec(!cur.outg, !cur.outg);
                    bufWr_d = 1'b1;
                    bufEnt_d = {baseAddr, 4'h0, cur.outg, cur.chan,
                        rec_d[7:0]};
                    if (cur.outg) begin
                        hold_d[cur.chan] = 1'b0;
                        grp_d[cur.chan] = 1'b0;
                    end else begin
                        grp_d[cur.chan] = 1'b1;
                    end
                end else if (!procIrq_d && |pendQ) begin
                    state_d = ST_PROC;
                    procIrq_d = 1'b1;
                    word_d = pendQ;
                    base_d = baseAddr;
                    procCh_d = chanOf(pendQ);
                    pend_d = keepBits;
                end else begin
                    state_d = procIrq_d ? ST_PROC : ST_IDLE;
                end
            end
            ST_DIAG: begin
                if (diagDone) begin
                    diagIrq_d = 1'b0;
                    state_d = procIrq_d ? ST_PROC : ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (push) begin
            wr_d = wrQ + 4'h1;
            cnt_d = cnt_d + 5'h1;
        end
        fault_d = |hold_d;
    end

    always_comb begin
        case (rdIdx)
            `PDI_REC_ERR: rdData_d = recQ[7:0];
            `PDI_REC_CLASS: rdData_d = recQ[15:8];
            `PDI_REC_ZERO: rdData_d = recQ[23:16];
            `PDI_REC_LOST: rdData_d = recQ[31:24];
            `PDI_REC1_TYPE: rdData_d = `PDI_CH_TYPE;
            `PDI_REC1_BITS: rdData_d = `PDI_DIAG_BITS;
            `PDI_REC1_CHANS: rdData_d = `PDI_CH_COUNT;
            default: rdData_d = {1'b0, grpQ};
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            procIrqQ <= 1'b0;
            diagIrqQ <= 1'b0;
            wordQ <= '0;
            baseQ <= '0;
            procChQ <= '0;
            pendQ <= '0;
            holdQ <= '0;
            incQ <= '0;
            outQ <= '0;
            trigQ <= '0;
            recQ <= '0;
            grpQ <= '0;
            bufWrQ <= 1'b0;
            bufEntQ <= '0;
            globQ <= 1'b0;
            wrQ <= '0;
            rdQ <= '0;
            cntQ <= '0;
            faultQ <= 1'b0;
            rdQ_data <= '0;
        end else begin
            state_q <= state_d;
            procIrqQ <= procIrq_d;
            diagIrqQ <= diagIrq_d;
            wordQ <= word_d;
            baseQ <= base_d;
            procChQ <= procCh_d;
            pendQ <= pend_d;
            holdQ <= hold_d;
            incQ <= inc_d;
            outQ <= out_d;
            trigQ <= trig_d;
            recQ <= rec_d;
            grpQ <= grp_d;
            bufWrQ <= bufWr_d;
            bufEntQ <= bufEnt_d;
            globQ <= glob_d;
            wrQ <= wr_d;
            rdQ <= rd_d;
            cntQ <= cnt_d;
            faultQ <= fault_d;
            rdQ_data <= rdData_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            qMem[wrQ] <= pushEnt;
        end
    end

    assign procIrq = procIrqQ;
    assign eventWord = wordQ;
    assign eventBase = baseQ;
    assign diagIrq = diagIrqQ;
    assign diagRecord = recQ;
    assign faultLed = faultQ;
    assign bufWr = bufWrQ;
    assign bufEntry = bufEntQ;
    assign rdData = rdQ_data;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_pend_gated: assert property (
        !procEn |=> (pendQ & ~$past(pendQ)) == 32'h0)
        else $error("pending events grew while reports disabled");
    a_count_rsv: assert property (
        procIrqQ && techMode == MODE_COUNT
        && $past(techMode) == MODE_COUNT && $past(techMode, 2) == MODE_COUNT
        |-> (eventWord & `PDI_RSV_COUNT) == 32'h0)
        else $error("reserved counter bits set");
    a_freq_rsv: assert property (
        $rose(procIrqQ) && techMode == MODE_FREQ
        && $past(techMode) == MODE_FREQ && $past(techMode, 2) == MODE_FREQ
        |-> (eventWord & `PDI_RSV_FREQ) == 32'h0)
        else $error("reserved frequency bits set");
    a_preempt_proc: assert property (
        procIrqQ && !diagIrqQ && cntQ != 5'h0 |=> diagIrqQ && procIrqQ)
        else $error("queued diagnostic did not preempt");
    a_repeat_incoming: assert property (
        diagEn && |repCh |=> (holdQ & $past(repCh)) == $past(repCh)
        ##[1:16] $rose(diagIrqQ))
        else $error("repeat event raised no incoming diagnostic");
    a_buf_entry: assert property (
        $rose(diagIrqQ) |-> bufWrQ && bufEntQ[7:0] == diagRecord[7:0])
        else $error("diagnostic dispatch without buffer entry");
    a_fault_lit: assert property (
        $rose(diagIrqQ) && !bufEntQ[11] |-> faultQ)
        else $error("fault indicator dark during incoming");
    a_record_fixed: assert property (
        diagIrqQ |-> diagRecord[23:16] == 8'h0 && diagRecord[1] == 1'b0
        && diagRecord[7:4] == 4'h0 && diagRecord[15:13] == 3'h0
        && diagRecord[11:8] == `PDI_CLASS_DIGITAL)
        else $error("fixed record bits wrong");
    a_outgoing_after: assert property (
        procDone && procIrqQ && |trigQ
        |=> |outQ || $past(push && pushEnt.outg))
        else $error("finished process gave no outgoing diagnostic");
    a_held_drop: assert property (
        |dropCh |=> (pendQ & bitsOf($past(dropCh))) == 32'h0
        || $past(pendQ & bitsOf(dropCh)) != 32'h0)
        else $error("event of held channel was kept");

    c_proc_served: cover property ($rose(procIrqQ) ##[1:20] $fell(procIrqQ));
    c_incoming: cover property ($rose(diagIrqQ) && !bufEntQ[11]);
    c_outgoing: cover property ($rose(diagIrqQ) && bufEntQ[11]);
    c_preempted: cover property (procIrqQ && $rose(diagIrqQ));
endmodule // process_diag_interrupt_unit

/* dv/testbench.sv */
// Self-checking bench of the process and diagnostic interrupt unit.
// Assumes the handlers' done pulses are driven here at the falling edge.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pdi_pkg::*;
    localparam logic [15:0] BASE = 16'h1234;
    localparam int LIMIT = 8000;
    logic clk, arst_n, diagProcCfg, counterOutEn, paramWr;
    logic procDone, diagDone;
    logic [15:0] inPins;
    logic [11:0] ctrEvt;
    logic [2:0] freqEnd, rdIdx;
    logic [7:0] paramIdx, paramData;
    mode_e techMode;
    logic procIrq, diagIrq, faultLed, bufWr;
    logic [31:0] eventWord, diagRecord, bufEntry;
    logic [15:0] eventBase, baseAddr;
    logic [7:0] rdData;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;

    process_diag_interrupt_unit DUT (.clk(clk), .arst_n(arst_n),
        .inPins(inPins), .ctrEvt(ctrEvt), .freqEnd(freqEnd),
        .techMode(techMode), .diagProcCfg(diagProcCfg),
        .counterOutEn(counterOutEn), .paramWr(paramWr),
        .paramIdx(paramIdx), .paramData(paramData), .baseAddr(baseAddr),
        .procDone(procDone), .diagDone(diagDone), .rdIdx(rdIdx),
        .procIrq(procIrq), .eventWord(eventWord),
        .eventBase(eventBase), .diagIrq(diagIrq),
        .diagRecord(diagRecord), .faultLed(faultLed), .bufWr(bufWr),
        .bufEntry(bufEntry), .rdData(rdData));

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmpBit(input logic got, exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    function automatic logic sigOf(input bit diag);
        return diag ? diagIrq : procIrq;
    endfunction

    // Bounded wait, returns at a falling edge
    task automatic waitFor(input bit diag, input logic v, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clk);
            if (sigOf(diag) === v) break;
        end
        cmpBit(sigOf(diag), v, "request level");
    endtask

    task automatic pulseCtr(input int i);
        @(negedge clk);
        ctrEvt[i] = 1'b1;
        @(negedge clk);
        ctrEvt = '0;
    endtask

    task automatic pulseDone(input bit diag);
        @(negedge clk);
        if (diag) diagDone = 1'b1;
        else procDone = 1'b1;
        @(negedge clk);
        diagDone = 1'b0;
        procDone = 1'b0;
    endtask

    task automatic setGlobal(input logic v);
        @(negedge clk);
        paramWr = 1'b1;
        paramIdx = 8'h7f;
        paramData = {7'h0, v};
        @(negedge clk);
        paramWr = 1'b0;
    endtask

    task automatic serve(input logic [31:0] exp);
        waitFor(1'b0, 1'b1, 12);
        cmp(eventWord, exp, "event word");
        cmp({16'h0, eventBase}, {16'h0, baseAddr}, "base address");
        pulseDone(1'b0);
        waitFor(1'b0, 1'b0, 4);
    endtask

    task automatic expectQuiet(input int n);
        repeat (n) begin
            @(negedge clk);
            cmpBit(procIrq, 1'b0, "no process request");
        end
    endtask

    task automatic readRec(input logic [2:0] idx, input logic [7:0] exp);
        @(negedge clk);
        rdIdx = idx;
        @(negedge clk);
        cmp({24'h0, rdData}, {24'h0, exp}, "record byte");
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        cmp({procIrq, diagIrq, faultLed, bufWr}, 32'h0, "reset flags");
        cmp(eventWord | diagRecord, 32'h0, "reset words");
    endtask

    task automatic t_pins();
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            inPins[i] = ~inPins[i];
            serve(32'h1 << i);
        end
    endtask

    task automatic t_counter();
        for (int i = 0; i < 12; i++) begin
            pulseCtr(i);
            serve(32'h1 << (16 + i));
        end
    endtask

    task automatic t_freq();
        techMode = MODE_FREQ;
        baseAddr = 16'h5678;
        @(negedge clk);
        inPins[5] = ~inPins[5];
        serve(32'h20);
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            freqEnd[k] = 1'b1;
            @(negedge clk);
            freqEnd = '0;
            serve(32'h1 << (16 + 4 * k));
        end
        techMode = MODE_COUNT;
        baseAddr = BASE;
    endtask

    task automatic t_refuse();
        counterOutEn = 1'b0;
        pulseCtr(0);
        expectQuiet(10);
        counterOutEn = 1'b1;
        diagProcCfg = 1'b0;
        pulseCtr(1);
        expectQuiet(10);
        diagProcCfg = 1'b1;
        techMode = MODE_PWM;
        pulseCtr(2);
        inPins[0] = ~inPins[0];
        expectQuiet(10);
        techMode = MODE_COUNT;
        expectQuiet(5);
    endtask

    task automatic t_diag();
        logic [7:0] tbl [8];
        tbl = '{8'h08, 8'h1f, 8'h00, 8'h40, 8'h70, 8'h08, 8'h08, 8'h10};
        pulseCtr(0);
        waitFor(1'b0, 1'b1, 12);
        pulseCtr(0);
        waitFor(1'b1, 1'b1, 10);
        cmp(diagRecord, 32'h4000_1f08, "incoming record");
        cmpBit(bufWr, 1'b1, "buffer write");
        cmp(bufEntry, {BASE, 4'h0, 1'b0, 3'h4, 8'h08}, "entry");
        cmpBit(procIrq, 1'b1, "preempted service");
        cmpBit(faultLed, 1'b1, "fault lit");
        pulseCtr(1);
        for (int i = 0; i < 8; i++) begin
            readRec(3'(i), tbl[i]);
        end
        pulseDone(1'b1);
        waitFor(1'b1, 1'b0, 4);
        cmp(eventWord, 32'h0001_0000, "served word kept");
        pulseDone(1'b0);
        waitFor(1'b1, 1'b1, 10);
        cmp(diagRecord, 32'h0000_1f00, "outgoing record");
        cmpBit(bufWr, 1'b1, "buffer write");
        cmp(bufEntry, {BASE, 4'h0, 1'b1, 3'h4, 8'h00}, "entry");
        pulseDone(1'b1);
        waitFor(1'b1, 1'b0, 4);
        cmpBit(faultLed, 1'b0, "fault off");
        expectQuiet(10);
    endtask

    task automatic t_disabled();
        setGlobal(1'b0);
        pulseCtr(8);
        waitFor(1'b0, 1'b1, 12);
        pulseCtr(8);
        repeat (10) begin
            @(negedge clk);
            cmpBit(diagIrq, 1'b0, "no diagnostic");
        end
        readRec(3'h3, 8'h40);
        readRec(3'h7, 8'h40);
        pulseDone(1'b0);
        waitFor(1'b0, 1'b0, 4);
        cmpBit(faultLed, 1'b0, "fault off");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        inPins = '0;
        ctrEvt = '0;
        freqEnd = '0;
        techMode = MODE_COUNT;
        diagProcCfg = 1'b1;
        counterOutEn = 1'b1;
        paramWr = 1'b0;
        paramIdx = 8'h00;
        paramData = 8'h00;
        procDone = 1'b0;
        diagDone = 1'b0;
        rdIdx = 3'h0;
        baseAddr = BASE;
        repeat (8) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        t_reset();
        setGlobal(1'b1);
        repeat (4) @(negedge clk);
        t_pins();
        t_counter();
        t_freq();
        t_refuse();
        t_diag();
        t_disabled();
        wrap_up();
    end
endmodule // testbench
